// File: core/bus_cmd_pkg.sv
// package: cycle-type codes, states and timing counts for the bus command controller
package bus_cmd_pkg;
	// decoded bus-cycle types, {qualifier, status1, status0}
	localparam logic [2:0] CYC_INTA = 3'h0;
	localparam logic [2:0] CYC_IO_RD = 3'h1;
	localparam logic [2:0] CYC_IO_WR = 3'h2;
	localparam logic [2:0] CYC_IDLE0 = 3'h3;
	localparam logic [2:0] CYC_HALT = 3'h4;
	localparam logic [2:0] CYC_MEM_RD = 3'h5;
	localparam logic [2:0] CYC_MEM_WR = 3'h6;
	localparam logic [2:0] CYC_IDLE1 = 3'h7;
	// command output bit positions
	localparam int CMD_INTA_BIT = 0;
	localparam int CMD_IORD_BIT = 1;
	localparam int CMD_IOWR_BIT = 2;
	localparam int CMD_MRD_BIT = 3;
	localparam int CMD_MWR_BIT = 4;
	localparam int CMD_W = 5;
	localparam logic [4:0] CMD_NONE = 5'h00;
	// compatible mode holds the command one extra phase (two clocks) before it may start
	localparam logic [1:0] LEGACY_WAIT = 2'h1;
	localparam logic [1:0] SHORT_WAIT = 2'h0;
	localparam logic [1:0] WAIT_RESET = 2'h0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STATUS = 4'b0010,
		ST_DELAY = 4'b0100,
		ST_CMD = 4'b1000
	} cyc_state_e;
endpackage

// File: core/bus_cycle_command_control.sv
// bus command controller front end: cycle decode, enable latch, command delay
module bus_cycle_command_control (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic CYCLE_STATUS_BIT0_N_I,
	input wire logic CYCLE_STATUS_BIT1_N_I,
	input wire logic MEM_IO_SEL_I,
	input wire logic TIMING_MODE_STRAP_I,
	input wire logic CYCLE_ENABLE_LATCHED_I,
	input wire logic COMMAND_DELAY_IN_I,
	input wire logic READY_N_I,
	output logic INTA_CMD_N_O,
	output logic IO_READ_CMD_N_O,
	output logic IO_WRITE_CMD_N_O,
	output logic MEM_READ_CMD_N_O,
	output logic MEM_WRITE_CMD_N_O,
	output logic CYCLE_ACTIVE_O
);
	// =====================================================
	// input synchronisers
	// pins are asynchronous to our clock, so all pass two flops
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			sync1_reg <= 7'h03;
			sync2_reg <= 7'h03;
		end else begin
			sync1_reg <= {READY_N_I, COMMAND_DELAY_IN_I, CYCLE_ENABLE_LATCHED_I,
				TIMING_MODE_STRAP_I, MEM_IO_SEL_I, CYCLE_STATUS_BIT1_N_I,
				CYCLE_STATUS_BIT0_N_I};
			sync2_reg <= sync1_reg;
		end
	end
	logic s0_n;
	logic s1_n;
	logic mio;
	logic mode;
	logic cen;
	logic dly;
	logic rdy_n;
	assign s0_n = sync2_reg[0];
	assign s1_n = sync2_reg[1];
	assign mio = sync2_reg[2];
	assign mode = sync2_reg[3];
	assign cen = sync2_reg[4];
	assign dly = sync2_reg[5];
	assign rdy_n = sync2_reg[6];

	// =====================================================
	// processor-phase enable: cycles start on falling clock edges,
	// modelled as a divide-by-two phase pulse on our clock
	logic phase_reg;
	logic fall_en;
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= ~phase_reg;
		end
	end
	assign fall_en = phase_reg;

	// =====================================================
	// mode strap: caught once after reset release, since it never changes
	logic mode_reg;
	logic mode_arm_reg;
	logic mode_valid_reg;
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			mode_reg <= 1'b0;
			mode_arm_reg <= 1'b0;
			mode_valid_reg <= 1'b0;
		end else if (!mode_valid_reg && fall_en) begin
			// first pulse still sees the synchroniser's reset value, so wait one more
			mode_arm_reg <= 1'b1;
			if (mode_arm_reg) begin
				mode_reg <= mode;
				mode_valid_reg <= 1'b1;
			end
		end
	end

	// =====================================================
	// cycle decode
	logic [2:0] code;
	logic start;
	assign code = {mio, s1_n, s0_n};
	// either status low starts a cycle
	assign start = fall_en && mode_valid_reg && (!s0_n || !s1_n);

	logic [4:0] cmd_sel;
	always_comb begin
		cmd_sel = bus_cmd_pkg::CMD_NONE;
		case (code)
			bus_cmd_pkg::CYC_INTA: cmd_sel[bus_cmd_pkg::CMD_INTA_BIT] = 1'b1;
			bus_cmd_pkg::CYC_IO_RD: cmd_sel[bus_cmd_pkg::CMD_IORD_BIT] = 1'b1;
			bus_cmd_pkg::CYC_IO_WR: cmd_sel[bus_cmd_pkg::CMD_IOWR_BIT] = 1'b1;
			bus_cmd_pkg::CYC_MEM_RD: cmd_sel[bus_cmd_pkg::CMD_MRD_BIT] = 1'b1;
			bus_cmd_pkg::CYC_MEM_WR: cmd_sel[bus_cmd_pkg::CMD_MWR_BIT] = 1'b1;
			default: cmd_sel = bus_cmd_pkg::CMD_NONE;
		endcase
	end

	// =====================================================
	// cycle state machine
	bus_cmd_pkg::cyc_state_e state_reg;
	bus_cmd_pkg::cyc_state_e state_next;
	logic [4:0] type_reg;
	logic en_reg;
	logic [1:0] wait_reg;
	logic [4:0] cmd_reg;
	logic [4:0] cmd_n_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bus_cmd_pkg::ST_IDLE: begin
				if (start) begin
					state_next = bus_cmd_pkg::ST_STATUS;
				end
			end
			bus_cmd_pkg::ST_STATUS: begin
				if (fall_en) begin
					state_next = bus_cmd_pkg::ST_DELAY;
				end
			end
			bus_cmd_pkg::ST_DELAY: begin
				// ready during delay ends cycle, no command
				if (fall_en && !rdy_n && wait_reg == bus_cmd_pkg::WAIT_RESET) begin
					state_next = bus_cmd_pkg::ST_IDLE;
				end else if (fall_en && en_reg && !dly &&
						wait_reg == bus_cmd_pkg::WAIT_RESET) begin
					state_next = bus_cmd_pkg::ST_CMD;
				end
			end
			bus_cmd_pkg::ST_CMD: begin
				if (fall_en && !rdy_n) begin
					state_next = bus_cmd_pkg::ST_IDLE;
				end
			end
			default: state_next = bus_cmd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			state_reg <= bus_cmd_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// cycle type captured at start
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			type_reg <= bus_cmd_pkg::CMD_NONE;
		end else if (state_reg == bus_cmd_pkg::ST_IDLE && start) begin
			type_reg <= cmd_sel;
		end
	end

	// enable latched at end of status state
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			en_reg <= 1'b0;
		end else if (state_reg == bus_cmd_pkg::ST_STATUS && fall_en) begin
			en_reg <= cen;
		end
	end

	// compatible timing inserts one extra phase before command
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			wait_reg <= bus_cmd_pkg::WAIT_RESET;
		end else if (state_reg == bus_cmd_pkg::ST_STATUS && fall_en) begin
			wait_reg <= mode_reg ? bus_cmd_pkg::LEGACY_WAIT : bus_cmd_pkg::SHORT_WAIT;
		end else if (state_reg == bus_cmd_pkg::ST_DELAY && fall_en &&
				wait_reg != bus_cmd_pkg::WAIT_RESET) begin
			wait_reg <= wait_reg - 2'h1;
		end
	end

	// command only in command state with enable latched high
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			cmd_reg <= bus_cmd_pkg::CMD_NONE;
			cmd_n_reg <= ~bus_cmd_pkg::CMD_NONE;
		end else if (state_next == bus_cmd_pkg::ST_CMD && en_reg) begin
			cmd_reg <= type_reg;
			cmd_n_reg <= ~type_reg;
		end else begin
			cmd_reg <= bus_cmd_pkg::CMD_NONE;
			cmd_n_reg <= ~bus_cmd_pkg::CMD_NONE;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			CYCLE_ACTIVE_O <= 1'b0;
		end else begin
			CYCLE_ACTIVE_O <= (state_next != bus_cmd_pkg::ST_IDLE);
		end
	end

	// active-low copies kept in flops so the pins see no gate after the register
	assign INTA_CMD_N_O = cmd_n_reg[bus_cmd_pkg::CMD_INTA_BIT];
	assign IO_READ_CMD_N_O = cmd_n_reg[bus_cmd_pkg::CMD_IORD_BIT];
	assign IO_WRITE_CMD_N_O = cmd_n_reg[bus_cmd_pkg::CMD_IOWR_BIT];
	assign MEM_READ_CMD_N_O = cmd_n_reg[bus_cmd_pkg::CMD_MRD_BIT];
	assign MEM_WRITE_CMD_N_O = cmd_n_reg[bus_cmd_pkg::CMD_MWR_BIT];

	// =====================================================
	// assertions
	// command released after ready
	ready_release_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_CMD && fall_en && !rdy_n) |=> cmd_reg == 5'h00)
		else $error("command still active after ready");
	disabled_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		!en_reg && state_reg == bus_cmd_pkg::ST_DELAY |=> cmd_reg == 5'h00)
		else $error("command issued on disabled cycle");
	delay_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_DELAY && fall_en && dly) |=>
			state_reg != bus_cmd_pkg::ST_CMD)
		else $error("command not held by delay input");
	delay_go_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_DELAY && fall_en && !dly && rdy_n && en_reg &&
			wait_reg == 2'h0) |=> ##1 cmd_reg == type_reg)
		else $error("command not enabled after delay low");
	delay_ready_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_DELAY && fall_en && !rdy_n && wait_reg == 2'h0) |=>
			state_reg == bus_cmd_pkg::ST_IDLE)
		else $error("cycle not ended by ready during delay");
	cycle_start_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_IDLE && start) |=> state_reg == bus_cmd_pkg::ST_STATUS)
		else $error("cycle start missed");
	cmd_onehot_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		$onehot0(cmd_reg))
		else $error("more than one command active");
	enable_latch_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_STATUS && fall_en) |=> en_reg == $past(cen))
		else $error("cycle enable not latched");
	// compatible mode waits one extra phase
	legacy_wait_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_STATUS && fall_en && mode_reg) |=> wait_reg == 2'h1)
		else $error("compatible wait not loaded");
	// io cycle never drives memory commands
	io_space_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state_reg == bus_cmd_pkg::ST_IDLE && start && !mio) |=> type_reg[4:3] == 2'h0)
		else $error("io cycle selected memory command");
	mem_read_c: cover property (@(posedge CLOCK_I) cmd_reg[bus_cmd_pkg::CMD_MRD_BIT]);
	io_write_c: cover property (@(posedge CLOCK_I) cmd_reg[bus_cmd_pkg::CMD_IOWR_BIT]);
	abort_c: cover property (@(posedge CLOCK_I) state_reg == bus_cmd_pkg::ST_DELAY &&
		fall_en && !rdy_n);
endmodule

// File: sim/bus_cycle_command_control_tb_top.sv
// bench: cycle decode, command delay, enable and timing mode checks
`define CHK(w, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h seen %h", w, e, s); end end
module bus_cycle_command_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b0;
	logic en = 1'b1;
	logic dly = 1'b0;
	logic rdy_n = 1'b1;
	logic go = 1'b0;
	logic [2:0] code = 3'h0;
	wire s0, s1, mio, act;
	wire [4:0] cmd_n;
	int n_errors = 0, total_checks = 0, lat, lat_s, n, i;
	// one-hot low command per cycle code, index is {qualifier, s1, s0}
	logic [4:0] exp_cmd [8] = '{5'h1e, 5'h1d, 5'h1b, 5'h1f, 5'h1f, 5'h17, 5'h0f, 5'h1f};
	always #2 clock = ~clock;
	cpu_status_model cpu_u (.clock_i(clock), .go_i(go), .code_i(code),
		.mem_io_o(mio), .s1_n_o(s1), .s0_n_o(s0));
	bus_cycle_command_control dut_u (.CLOCK_I(clock), .RST_N_I(rst_n),
		.CYCLE_STATUS_BIT0_N_I(s0), .CYCLE_STATUS_BIT1_N_I(s1), .MEM_IO_SEL_I(mio),
		.TIMING_MODE_STRAP_I(strap), .CYCLE_ENABLE_LATCHED_I(en),
		.COMMAND_DELAY_IN_I(dly), .READY_N_I(rdy_n), .INTA_CMD_N_O(cmd_n[0]),
		.IO_READ_CMD_N_O(cmd_n[1]), .IO_WRITE_CMD_N_O(cmd_n[2]),
		.MEM_READ_CMD_N_O(cmd_n[3]), .MEM_WRITE_CMD_N_O(cmd_n[4]), .CYCLE_ACTIVE_O(act));
	// ==========================
	// tasks
	task automatic step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic do_reset(input logic m);
		rst_n = 1'b0;
		strap = m;
		step(3);
		`CHK("reset cmd", 5'h1f, cmd_n)
		`CHK("reset active", 1'b0, act)
		rst_n = 1'b1;
		step(4);
	endtask
	// bounded wait: a missing command leaves lat at 40
	task automatic run(input logic [2:0] c);
		code = c;
		go = 1'b1;
		step(1);
		go = 1'b0;
		lat = 0;
		while (cmd_n === 5'h1f && lat < 40) begin
			step(1);
			lat++;
		end
	endtask
	task automatic finish_cycle();
		rdy_n = 1'b0;
		n = 0;
		while (act !== 1'b0 && n < 40) begin
			step(1);
			n++;
		end
		step(1);
		`CHK("end active", 1'b0, act)
		`CHK("end cmd", 5'h1f, cmd_n)
		rdy_n = 1'b1;
		step(4);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================
	// watchdog
	initial begin
		#40000;
		n_errors++;
		results();
	end
	// ==========================
	// sequence
	initial begin
		step(0);
		do_reset(1'b0);
		for (i = 0; i < 8; i++) begin
			run(i[2:0]);
			if (i == 0)
				lat_s = lat;
			`CHK("command", exp_cmd[i], cmd_n)
			finish_cycle();
		end
		dly = 1'b1;
		run(3'h5);
		`CHK("delayed cmd", 5'h1f, cmd_n)
		dly = 1'b0;
		run(3'h7);
		`CHK("released cmd", 5'h17, cmd_n)
		finish_cycle();
		dly = 1'b1;
		run(3'h2);
		`CHK("abort cmd", 5'h1f, cmd_n)
		finish_cycle();
		dly = 1'b0;
		en = 1'b0;
		step(4);
		run(3'h1);
		`CHK("disabled cmd", 5'h1f, cmd_n)
		finish_cycle();
		en = 1'b1;
		do_reset(1'b1);
		run(3'h0);
		`CHK("compat cmd", 5'h1e, cmd_n)
		`CHK("compat gap", 2, lat - lat_s)
		finish_cycle();
		results();
	end
endmodule

// File: sim/cpu_status_model.sv
// processor model: drives status and memory/io select for one cycle
module cpu_status_model (
	input wire logic clock_i,
	input wire logic go_i,
	input wire logic [2:0] code_i,
	output logic mem_io_o,
	output logic s1_n_o,
	output logic s0_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] hold_reg = 3'h0;
	logic [2:0] code_reg = 3'h7;
	// ==========================
	// status drive
	always @(posedge clock_i) begin
		if (go_i) begin
			hold_reg <= 3'h4;
			code_reg <= code_i;
		end else if (hold_reg != 3'h0) begin
			hold_reg <= hold_reg - 3'h1;
		end
	end
	// status low starts cycle
	// held four clocks so a phase pulse always sees it; idle is both high
	assign s1_n_o = (hold_reg == 3'h0) | code_reg[1];
	assign s0_n_o = (hold_reg == 3'h0) | code_reg[0];
	assign mem_io_o = code_reg[2];
endmodule
